// >>> rtl/pdq_pkg.sv
// pdq_pkg: shared constants and types for the predecode / fusion / loop replay block
// assumes a single core clock; fetch lines arrive as 16 bytes with a start offset
package pdq_pkg;
  localparam int unsigned LINE_BYTES     = 16;
  localparam int unsigned MAX_INSN_BYTES = 15;
  localparam int unsigned FAST_CYCLES    = 1;
  localparam int unsigned SLOW_CYCLES    = 6;
  localparam int unsigned DOUBLE_CYCLES  = 11;
  localparam logic [3:0]  DBL_DISP_OFS   = 4'hD;
  localparam logic [3:0]  FALSE_OFS      = 4'hE;
  localparam logic [7:0]  OPSIZE_PFX     = 8'h66;
  localparam logic [7:0]  ADDRSIZE_PFX   = 8'h67;
  localparam logic [7:0]  GRP_F7_OP      = 8'hF7;
  localparam logic [3:0]  REXT_HI        = 4'h4;
  localparam int unsigned LOOP_MAX_FETCH = 4;
  localparam int unsigned LOOP_MAX_INSN  = 18;
  localparam int unsigned LOOP_MAX_TAKEN = 4;
  localparam logic [3:0]  PEN_RESET      = 4'h0;

  // instruction classes seen by the fusion detector
  typedef enum logic [2:0] {
    PDQ_OTHER   = 3'h0,
    PDQ_CMP     = 3'h1,
    PDQ_TEST    = 3'h2,
    PDQ_JCC     = 3'h3,
    PDQ_JMP     = 3'h4,
    PDQ_RET     = 3'h5
  } pdq_cls_t;

  // operand forms of a compare
  typedef enum logic [1:0] {
    PDQ_RR = 2'h0,
    PDQ_RI = 2'h1,
    PDQ_RM = 2'h2,
    PDQ_MI = 2'h3
  } pdq_form_t;

  // branch condition flag group
  typedef enum logic [1:0] {
    PDQ_CC_CZ    = 2'h0,
    PDQ_CC_SIGN  = 2'h1,
    PDQ_CC_OTHER = 2'h2
  } pdq_cc_t;
endpackage : pdq_pkg

// >>> rtl/pdq_fuse_if.sv
// pdq_fuse_if: carries one decoded pair from the predecoder to the fusion detector
// assumes both ends share the core clock
interface pdq_fuse_if;
  import pdq_pkg::*;
  logic      valid;
  pdq_cls_t  first_cls;
  pdq_form_t first_form;
  logic      self_test;
  pdq_cls_t  second_cls;
  pdq_cc_t   second_cc;
  logic      long_mode;
  logic      fuse;
  modport src (output valid, first_cls, first_form, self_test, second_cls, second_cc,
               long_mode, input fuse);
  modport dst (input valid, first_cls, first_form, self_test, second_cls, second_cc,
               long_mode, output fuse);
endinterface : pdq_fuse_if

// >>> rtl/pdq_fuse.sv
// pdq_fuse: combinational compare/branch pair fusion decision
// assumes the classes come from the same cycle's predecode
module pdq_fuse
  import pdq_pkg::*;
(
  pdq_fuse_if.dst f
);
  logic first_ok;
  logic cc_ok;
  logic tst;

  always_comb begin
    // self-test flags match compare-with-zero, so it fuses like a test
    tst      = (f.first_cls == PDQ_TEST) || f.self_test; // RULE3
    first_ok = (f.first_cls == PDQ_CMP) || tst; // RULE19
    // compare pairs only with carry/zero branches; test with any
    cc_ok    = tst || (f.second_cc == PDQ_CC_CZ); // RULE1 RULE19
    f.fuse   = f.valid && first_ok && (f.second_cls == PDQ_JCC) && cc_ok
               && (f.first_form != PDQ_MI) // RULE2
               && !f.long_mode; // RULE18
  end
endmodule : pdq_fuse

// >>> rtl/pdq_top.sv
// pdq_top: predecode length estimation, prefix stall penalties, pair fusion, loop replay
// assumes fetch unit holds a line while line_ready is low; decoders always accept
// Operation
// RULE1 - fuse register-immediate compare with following unsigned above-or-equal branch
// RULE2 - never fuse memory-immediate compare with signed greater-or-equal branch
// RULE3 - self-test of a register behaves as compare with zero
// RULE4 - instruction lengths up to 15 bytes are accepted
// RULE5 - line normally one cycle; six cycles when a length-changing prefix present
// RULE6 - operand-size and address-size prefixes count as length-changing
// RULE7 - fixed sixteen-bit immediate without size prefix causes no stall
// RULE8 - register-extension prefix in 64-bit mode causes no penalty
// RULE9 - boundary between operand-form and scaled-index byte stalls twice
// RULE10 - offset 13 with byte displacement addressing stalls twice
// RULE11 - double stall costs eleven cycles in total
// RULE12 - no scaled-index byte, no byte displacement: single stall only
// RULE13 - prefixed F7 group instruction at offset 14 gives a false stall
// RULE14 - loop body at most four fetch lines
// RULE15 - loop body at most eighteen instructions
// RULE16 - reject loop with over four taken branches or any return
// RULE17 - qualifying loop is replayed from the instruction queue
// RULE18 - no fusion in 64-bit mode
// RULE19 - compare or self-test then adjacent conditional branch; compare needs carry/zero
// RULE20 - withhold output and hold the line during penalty cycles
module pdq_top
  import pdq_pkg::*;
#(
  parameter int unsigned LINE_W = LINE_BYTES * 8
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              line_valid,
  output logic                   line_ready,
  input  wire logic [LINE_W-1:0] line_bytes,
  input  wire logic [3:0]        insn_ofs,
  input  wire logic [3:0]        insn_len,
  input  wire logic              has_osize_pfx,
  input  wire logic              has_asize_pfx,
  input  wire logic              has_rext_pfx,
  input  wire logic              fixed_sixteen_bit_immediate,
  input  wire logic              has_sib,
  input  wire logic              has_disp8,
  input  wire logic              long_mode,
  input  wire pdq_cls_t          first_cls,
  input  wire pdq_form_t         first_form,
  input  wire logic              self_test,
  input  wire pdq_cls_t          second_cls,
  input  wire pdq_cc_t           second_cc,
  input  wire logic              insn_retire,
  input  wire logic              branch_taken,
  input  wire pdq_cls_t          branch_cls,
  input  wire logic              loop_back,
  input  wire logic              loop_exit,
  output logic                   dec_valid,
  output logic [LINE_W-1:0]      dec_bytes,
  output logic                   dec_fused,
  output logic                   len_error,
  output logic                   stall_double,
  output logic                   replay_active
);
  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_STALL = 3'b010,
    ST_OUT   = 3'b100
  } pdq_st_t;

  typedef struct packed {
    pdq_st_t           st;
    logic [3:0]        pen;
    logic [LINE_W-1:0] bytes;
    logic              fused;
    logic              dbl;
    logic              lerr;
    logic [2:0]        fetches;
    logic [4:0]        insns;
    logic [2:0]        taken;
    logic              bad;
    logic              replay;
  } pdq_state_t;

  pdq_state_t s_q;
  pdq_state_t s_d;
  logic       fuse_w;
  logic       length_changing_prefix;
  logic       dbl;
  logic       fls;
  logic       hit;
  logic [4:0] end_pos;

  pdq_fuse_if fif ();
  assign fif.valid      = line_valid;
  assign fif.first_cls  = first_cls;
  assign fif.first_form = first_form;
  assign fif.self_test  = self_test;
  assign fif.second_cls = second_cls;
  assign fif.second_cc  = second_cc;
  assign fif.long_mode  = long_mode;
  assign fuse_w         = fif.fuse;

  pdq_fuse u_fuse (
    .f (fif)
  );

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    end_pos = 5'(insn_ofs) + 5'(insn_len);
    // fixed sixteen_bit_immediate without size prefix is never a length change; rex never counts
    length_changing_prefix = (has_osize_pfx || has_asize_pfx) && !fixed_sixteen_bit_immediate; // RULE6 RULE7 RULE8
    // sib split across boundary or disp8 at offset 13: stall per line
    dbl = length_changing_prefix && ((has_sib && (end_pos > 5'(LINE_BYTES)) && insn_ofs >= 4'hD) // RULE9
                  || (has_disp8 && insn_ofs == DBL_DISP_OFS)); // RULE10 RULE12
    // F7 opcode at byte 14 or 15, length byte in next line
    fls = has_osize_pfx && (insn_ofs == FALSE_OFS)
          && (line_bytes[8*15 +: 8] == GRP_F7_OP || line_bytes[8*14 +: 8] == GRP_F7_OP); // RULE13
    hit = length_changing_prefix || fls;
  end

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      ST_IDLE: begin
        // nothing is taken while the queue replays, matching line_ready
        if (line_valid && !s_q.replay) begin
          s_d.bytes = line_bytes;
          s_d.fused = fuse_w;
          s_d.dbl   = dbl;
          s_d.lerr  = (insn_len > 4'(MAX_INSN_BYTES)) || (insn_len == 4'h0); // RULE4
          if (hit) begin
            // slow length path; double charges both lines
            s_d.pen = dbl ? 4'(DOUBLE_CYCLES - 1) : 4'(SLOW_CYCLES - 1); // RULE5 RULE11
            s_d.st  = ST_STALL;
          end else begin
            s_d.st  = ST_OUT; // RULE5
          end
        end
      end
      ST_STALL: begin
        s_d.pen = s_q.pen - 4'h1; // RULE20
        if (s_q.pen == 4'h1) begin
          s_d.st = ST_OUT;
        end
      end
      ST_OUT: begin
        s_d.st = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    // loop capture: count lines, instructions, taken branches per body
    if (loop_exit) begin
      s_d.replay  = 1'b0;
      s_d.fetches = 3'h0;
      s_d.insns   = 5'h0;
      s_d.taken   = 3'h0;
      s_d.bad     = 1'b0;
    end else if (!s_q.replay) begin
      if (s_q.st == ST_OUT && s_q.fetches != 3'h7) begin
        s_d.fetches = s_q.fetches + 3'h1;
      end
      if (insn_retire && s_q.insns != 5'h1F) begin
        s_d.insns = s_q.insns + 5'h1;
      end
      if (branch_taken) begin
        if (s_q.taken != 3'h7) begin
          s_d.taken = s_q.taken + 3'h1;
        end
        if (branch_cls == PDQ_RET) begin
          s_d.bad = 1'b1; // RULE16
        end
      end
      if (loop_back) begin
        // any failed limit restarts the count at the next body
        // closing cycle's own events still belong to the body being judged
        s_d.replay = !s_d.bad
                     && s_d.fetches <= 3'(LOOP_MAX_FETCH) // RULE14
                     && s_d.insns <= 5'(LOOP_MAX_INSN) // RULE15
                     && s_d.taken <= 3'(LOOP_MAX_TAKEN); // RULE16
        s_d.fetches = 3'h0;
        s_d.insns   = 5'h0;
        s_d.taken   = 3'h0;
        s_d.bad     = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{st: ST_IDLE, pen: PEN_RESET, bytes: '0, fused: 1'b0, dbl: 1'b0,
               lerr: 1'b0, fetches: 3'h0, insns: 5'h0, taken: 3'h0, bad: 1'b0,
               replay: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fetch is not drawn while replaying: queue supplies the body
  assign line_ready    = (s_q.st == ST_IDLE) && !s_q.replay; // RULE17 RULE20
  assign dec_valid     = (s_q.st == ST_OUT); // RULE20
  assign dec_bytes     = s_q.bytes;
  assign dec_fused     = s_q.fused;
  assign len_error     = s_q.lerr;
  assign stall_double  = s_q.dbl;
  assign replay_active = s_q.replay; // RULE17

  //////////////////////////////////////////////////////////////////////////////
  a_single_stall: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
    (s_q.st == ST_IDLE && line_valid && hit && !dbl && !s_q.replay) |->
      ##1 (!dec_valid) [*5] ##1 dec_valid)
    else $error("single stall length wrong");

  a_double_stall: assert property (@(posedge clk) disable iff (!arst_n) // RULE11
    (s_q.st == ST_IDLE && line_valid && dbl && !s_q.replay) |->
      ##1 (!dec_valid) [*8] ##1 (!dec_valid) [*2] ##1 dec_valid)
    else $error("double stall length wrong");

  a_fast_path: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
    (s_q.st == ST_IDLE && line_valid && !hit && !s_q.replay) |=> dec_valid)
    else $error("fast line not out next cycle");

  a_no_fuse_64: assert property (@(posedge clk) disable iff (!arst_n) // RULE18
    (s_q.st == ST_IDLE && line_valid && long_mode) |=> !dec_fused)
    else $error("fusion in 64-bit mode");

  a_mi_no_fuse: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
    (s_q.st == ST_IDLE && line_valid && first_form == PDQ_MI) |=> !dec_fused)
    else $error("mem-imm compare fused");

  a_ri_fuse: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
    (s_q.st == ST_IDLE && line_valid && !long_mode && first_cls == PDQ_CMP
     && first_form == PDQ_RI && second_cls == PDQ_JCC && second_cc == PDQ_CC_CZ)
      |=> dec_fused)
    else $error("reg-imm compare not fused");

  a_rext_free: assert property (@(posedge clk) disable iff (!arst_n) // RULE8
    (s_q.st == ST_IDLE && line_valid && has_rext_pfx && !has_osize_pfx
     && !has_asize_pfx) |=> dec_valid)
    else $error("extension prefix stalled");

  a_hold_line: assert property (@(posedge clk) disable iff (!arst_n) // RULE20
    (s_q.st == ST_STALL) |-> (!line_ready && !dec_valid) ##1 $stable(dec_bytes))
    else $error("line not held in stall");

  a_ret_reject: assert property (@(posedge clk) disable iff (!arst_n) // RULE16
    (!s_q.replay && !loop_exit && !loop_back && branch_taken && branch_cls == PDQ_RET
     && !s_q.bad) |=> s_q.bad)
    else $error("return not marked");
endmodule : pdq_top

// >>> verification/pdq_fetch_model.sv
// pdq_fetch_model: fetch unit stand-in offering one line per request
// assumes the bench raises send for one cycle and then waits for took
module pdq_fetch_model (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         send,
  input  wire logic [127:0] data,
  input  wire logic         line_ready,
  output logic              line_valid,
  output logic [127:0]      line_bytes,
  output logic              took
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line_valid <= 1'b0;
      line_bytes <= '0;
      took       <= 1'b0;
    end else if (line_valid && line_ready) begin
      // released bus shows inverse, so stale data cannot match
      line_valid <= 1'b0;
      line_bytes <= ~line_bytes;
      took       <= 1'b1;
    end else begin
      // offer held unchanged until taken
      took <= 1'b0;
      if (send && !line_valid) begin
        line_valid <= 1'b1;
        line_bytes <= data;
      end
    end
  end
endmodule : pdq_fetch_model

// >>> verification/predecode_prefix_stall_loop_replay_test.sv
// bench: latency, fusion and loop replay scenarios for pdq_top
// assumes pdq_pkg compiled first; fetch side is pdq_fetch_model
module predecode_prefix_stall_loop_replay_test;
  timeunit 1ns;
  timeprecision 100ps;
  import pdq_pkg::*;
  logic         clk = 0, arst_n = 0, send = 0, lr, lv, dv, fu, le, sd, ra, took;
  logic [127:0] lb, db, pat = '0;
  logic [3:0]   ofs = 0, len = 4'h3;
  logic         osz = 0, asz = 0, register_extension_prefix = 0, imm = 0, scaled_index_byte = 0, d8 = 0, lm = 0, st = 0;
  logic         ret = 0, tk = 0, lbk = 0, lx = 0;
  pdq_cls_t     c1 = PDQ_OTHER, c2 = PDQ_OTHER, bc = PDQ_OTHER;
  pdq_form_t    fm = PDQ_RR;
  pdq_cc_t      cc = PDQ_CC_OTHER;
  int           error_cnt = 0, total_checks = 0;
  always #2 clk = ~clk;
  pdq_fetch_model FM (.clk(clk), .arst_n(arst_n), .send(send), .data(pat),
    .line_ready(lr), .line_valid(lv), .line_bytes(lb), .took(took));
  pdq_top DUT (.clk(clk), .arst_n(arst_n), .line_valid(lv), .line_ready(lr),
    .line_bytes(lb), .insn_ofs(ofs), .insn_len(len), .has_osize_pfx(osz),
    .has_asize_pfx(asz), .has_rext_pfx(register_extension_prefix), .fixed_sixteen_bit_immediate(imm), .has_sib(scaled_index_byte),
    .has_disp8(d8), .long_mode(lm), .first_cls(c1), .first_form(fm), .self_test(st),
    .second_cls(c2), .second_cc(cc), .insn_retire(ret), .branch_taken(tk),
    .branch_cls(bc), .loop_back(lbk), .loop_exit(lx), .dec_valid(dv), .dec_bytes(db),
    .dec_fused(fu), .len_error(le), .stall_double(sd), .replay_active(ra));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(string nm, logic [127:0] e, logic [127:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %0h got %0h", nm, e, s);
    end
  endtask : chk
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask : cyc
  // one line through the predecoder, latency counted from the take edge
  task automatic line(logic [3:0] o, logic [3:0] n, logic [7:0] b, int lat,
                      logic dbl, logic er, logic fz);
    int k;
    ofs = o;
    len = n;
    pat = {8{8'h5A, o, n}};
    pat[119:112] = b;
    send = 1;
    cyc();
    send = 0;
    for (k = 0; k < 30 && !took; k++) cyc();
    if (!took) begin
      error_cnt++;
      summarize();
    end
    for (k = 1; k < 20 && dv !== 1'b1; k++) begin
      chk("line_ready in stall", 0, lr);
      cyc();
    end
    if (dv !== 1'b1) begin
      error_cnt++;
      summarize();
    end
    chk("latency", lat, k);
    chk("dec_bytes", pat, db);
    chk("stall_double", dbl, sd);
    chk("len_error", er, le);
    chk("dec_fused", fz, fu);
    cyc();
  endtask : line
  task automatic fuse(pdq_cls_t a, pdq_form_t f, logic t, pdq_cls_t b, pdq_cc_t c,
                      logic m, logic e);
    {osz, asz, register_extension_prefix, imm, scaled_index_byte, d8} = 6'h00;
    c1 = a;
    fm = f;
    st = t;
    c2 = b;
    cc = c;
    lm = m;
    line(4'h0, 4'h3, 8'h00, 1, 1'b0, 1'b0, e);
  endtask : fuse
  // body events then loop_back; replay expected one cycle later or never
  task automatic loopt(int nl, int nr, int nt, pdq_cls_t b, logic e);
    lx = 1;
    cyc();
    lx = 0;
    repeat (nl) line(4'h0, 4'h3, 8'h00, 1, 1'b0, 1'b0, 1'b0);
    ret = 1;
    repeat (nr) cyc();
    ret = 0;
    bc = b;
    tk = 1;
    repeat (nt) cyc();
    tk = 0;
    lbk = 1;
    cyc();
    lbk = 0;
    chk("replay_active", e, ra);
    if (e) chk("line_ready in replay", 0, lr);
    lx = 1;
    cyc();
    lx = 0;
    chk("replay cleared", 0, ra);
  endtask : loopt
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    #1;
    chk("reset ready", 1, lr);
    chk("reset outputs", 0, {dv, ra});
    arst_n = 1;
    line(4'h0, 4'h3, 8'h00, 1, 1'b0, 1'b0, 1'b0);
    {osz, asz, register_extension_prefix, imm, scaled_index_byte, d8, lm} = 7'h40;
    line(4'h2, 4'h4, 8'h00, 6, 1'b0, 1'b0, 1'b0);
    {osz, asz, register_extension_prefix, imm, scaled_index_byte, d8, lm} = 7'h20;
    line(4'h2, 4'h4, 8'h00, 6, 1'b0, 1'b0, 1'b0);
    {osz, asz, register_extension_prefix, imm, scaled_index_byte, d8, lm} = 7'h48;
    line(4'h1, 4'h4, 8'h00, 1, 1'b0, 1'b0, 1'b0);
    // false stall alone: prefix does not change length, f7 at offset 14
    line(4'hE, 4'h4, 8'hF7, 6, 1'b0, 1'b0, 1'b0);
    {osz, asz, register_extension_prefix, imm, scaled_index_byte, d8, lm} = 7'h11;
    line(4'h1, 4'h4, 8'h00, 1, 1'b0, 1'b0, 1'b0);
    {osz, asz, register_extension_prefix, imm, scaled_index_byte, d8, lm} = 7'h44;
    line(4'hD, 4'h7, 8'h00, 11, 1'b1, 1'b0, 1'b0);
    {osz, asz, register_extension_prefix, imm, scaled_index_byte, d8, lm} = 7'h42;
    line(4'hD, 4'h6, 8'h00, 11, 1'b1, 1'b0, 1'b0);
    {osz, asz, register_extension_prefix, imm, scaled_index_byte, d8, lm} = 7'h40;
    line(4'hD, 4'h6, 8'h00, 6, 1'b0, 1'b0, 1'b0);
    line(4'hE, 4'h4, 8'hF7, 6, 1'b0, 1'b0, 1'b0);
    {osz, asz, register_extension_prefix, imm, scaled_index_byte, d8, lm} = 7'h00;
    line(4'h0, 4'h0, 8'h00, 1, 1'b0, 1'b1, 1'b0);
    line(4'h0, 4'hF, 8'h00, 1, 1'b0, 1'b0, 1'b0);
    fuse(PDQ_CMP, PDQ_RI, 1'b0, PDQ_JCC, PDQ_CC_CZ, 1'b0, 1'b1);
    fuse(PDQ_CMP, PDQ_MI, 1'b0, PDQ_JCC, PDQ_CC_SIGN, 1'b0, 1'b0);
    fuse(PDQ_TEST, PDQ_MI, 1'b0, PDQ_JCC, PDQ_CC_SIGN, 1'b0, 1'b0);
    fuse(PDQ_TEST, PDQ_RR, 1'b1, PDQ_JCC, PDQ_CC_SIGN, 1'b0, 1'b1);
    fuse(PDQ_CMP, PDQ_RI, 1'b0, PDQ_JCC, PDQ_CC_SIGN, 1'b0, 1'b0);
    fuse(PDQ_CMP, PDQ_RI, 1'b0, PDQ_JMP, PDQ_CC_CZ, 1'b0, 1'b0);
    fuse(PDQ_CMP, PDQ_RI, 1'b0, PDQ_JCC, PDQ_CC_CZ, 1'b1, 1'b0);
    c1 = PDQ_OTHER;
    lm = 0;
    loopt(4, 18, 4, PDQ_JCC, 1'b1);
    loopt(5, 3, 1, PDQ_JCC, 1'b0);
    loopt(1, 19, 1, PDQ_JCC, 1'b0);
    loopt(1, 5, 5, PDQ_JCC, 1'b0);
    loopt(1, 5, 1, PDQ_RET, 1'b0);
    summarize();
  end
endmodule : predecode_prefix_stall_loop_replay_test
